// *** hw/mts_cc_channel.v ***
// Capture/compare channel watching one count value.
`timescale 1ns/100ps
module mts_cc_channel #(
  parameter W = 32
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire [W-1:0] cnt_i,
  input wire cap_edge_i,
  input wire en_i,
  input wire capmode_i,
  input wire periodic_i,
  input wire wr_i,
  input wire [W-1:0] wdata_i,
  output reg [W-1:0] val_o,
  output reg evt_o,
  output reg wave_o
);
  reg [W-1:0] prev_r;
  reg armed_r;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_r <= {W{1'b0}};
      val_o <= {W{1'b0}};
      evt_o <= 1'b0;
      wave_o <= 1'b0;
      armed_r <= 1'b1;
    end else begin
      prev_r <= cnt_i;
      evt_o <= 1'b0;
      if (!en_i) begin
        armed_r <= 1'b1;
      end else if (capmode_i) begin
        if (cap_edge_i && armed_r) begin
          val_o <= cnt_i;
          evt_o <= 1'b1;
          armed_r <= periodic_i;
        end
      end else if (armed_r && cnt_i == val_o && prev_r != val_o) begin
        evt_o <= 1'b1;
        wave_o <= ~wave_o;
        armed_r <= periodic_i;
      end
      // A write re-arms and beats a capture in the same cycle.
      if (wr_i) begin
        val_o <= wdata_i;
        armed_r <= 1'b1;
      end
    end
  end
endmodule

// *** hw/mts_counter.v ***
// Generic up-counter with one-shot, periodic, PWM and edge modes.
`timescale 1ns/100ps
`include "mts_defines.vh"
module mts_counter #(
  parameter W = 32
) (
  input wire mclk_i,
  input wire resetn_i,
  input wire en_i,
  input wire tick_i,
  input wire edge_i,
  input wire [2:0] mode_i,
  input wire [W-1:0] mask_i,
  input wire [W-1:0] load_i,
  input wire [W-1:0] match_i,
  output reg [W-1:0] cnt_o,
  output reg [W-1:0] capt_o,
  output reg evt_o,
  output reg out_o
);
  localparam [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam [W-1:0] ZERO = {W{1'b0}};
  reg done_r;
  reg [W-1:0] cnt_nxt;
  reg [W-1:0] capt_nxt;
  reg [W-1:0] inc;
  reg evt_nxt;
  reg out_nxt;
  reg done_nxt;
  always @* begin
    inc = (cnt_o + ONE) & mask_i;
    cnt_nxt = cnt_o;
    capt_nxt = capt_o;
    evt_nxt = 1'b0;
    out_nxt = out_o;
    done_nxt = done_r;
    if (!en_i) begin
      cnt_nxt = ZERO;
      done_nxt = 1'b0;
      out_nxt = 1'b0;
    end else begin
      case (mode_i)
        `MTS_MODE_ONESHOT: begin
          if (tick_i && !done_r) begin
            if (cnt_o == (load_i & mask_i)) begin
              evt_nxt = 1'b1;
              done_nxt = 1'b1;
              out_nxt = ~out_o;
            end else begin
              cnt_nxt = inc;
            end
          end
        end
        `MTS_MODE_PERIODIC, `MTS_MODE_PWM: begin
          if (tick_i) begin
            if (cnt_o == (load_i & mask_i)) begin
              cnt_nxt = ZERO;
              evt_nxt = 1'b1;
            end else begin
              cnt_nxt = inc;
            end
            if (mode_i == `MTS_MODE_PWM) begin
              out_nxt = (cnt_nxt < (match_i & mask_i));
            end else if (evt_nxt) begin
              out_nxt = ~out_o;
            end
          end
        end
        `MTS_MODE_EDGETIME: begin
          if (edge_i) begin
            capt_nxt = cnt_o;
            cnt_nxt = ZERO;
            evt_nxt = 1'b1;
            out_nxt = ~out_o;
          end else if (tick_i) begin
            cnt_nxt = inc;
          end
        end
        `MTS_MODE_EDGECNT: begin
          if (edge_i) begin
            if (inc == (match_i & mask_i)) begin
              cnt_nxt = ZERO;
              evt_nxt = 1'b1;
              out_nxt = ~out_o;
            end else begin
              cnt_nxt = inc;
            end
          end
        end
        default: begin
          cnt_nxt = cnt_o;
        end
      endcase
    end
  end
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_o <= ZERO;
      capt_o <= ZERO;
      evt_o <= 1'b0;
      out_o <= 1'b0;
      done_r <= 1'b0;
    end else begin
      cnt_o <= cnt_nxt;
      capt_o <= capt_nxt;
      evt_o <= evt_nxt;
      out_o <= out_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

// *** hw/mts_defines.vh ***
// Register map, field positions, reset values and mode codes of the timer block.
`ifndef MTS_DEFINES_VH
`define MTS_DEFINES_VH
// ---------------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------------
`define MTS_A_GCTRL 9'h000
`define MTS_A_STATUS 9'h004
`define MTS_A_RTC_INC 9'h008
`define MTS_A_RTC_LO 9'h00C
`define MTS_A_RTC_MID 9'h010
`define MTS_A_RTC_TOP 9'h014
`define MTS_A_RTC_CHCFG 9'h018
`define MTS_A_WDT_LOAD 9'h01C
`define MTS_A_WDT_CTRL 9'h020
`define MTS_A_WDT_KICK 9'h024
`define MTS_A_WDT_COUNT 9'h028
`define MTS_A_RAT_COUNT 9'h02C
`define MTS_A_AUX_CHCFG 9'h030
`define MTS_A_RAT_CHCFG 9'h034
`define MTS_A_CH_BASE 9'h040
`define MTS_A_CNT_BASE 9'h080
`define MTS_NUM_CH 9
`define MTS_NUM_CNT 11
`define MTS_CNT_SPAN 9'h160
`define MTS_SUB_CFG 3'h0
`define MTS_SUB_LOAD 3'h1
`define MTS_SUB_MATCH 3'h2
`define MTS_SUB_COUNT 3'h3
`define MTS_SUB_CAPT 3'h4
// ---------------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------------
`define MTS_GC_RTC_DBGSTOP 0
`define MTS_GC_SPLIT_LSB 1
`define MTS_GCTRL_RST 32'h0000_0001
`define MTS_RTC_INC_RST 32'h0002_0000
`define MTS_WDT_LOAD_RST 32'hFFFF_FFFF
`define MTS_RAT_TICKS_PER_SEC 22'h3D_0900
`define MTS_CF_EN 3
`define MTS_CF_SRC 8
`define MTS_STATUS_W 21
`define MTS_ST_WDT 20
`define MTS_MASK16 32'h0000_FFFF
`define MTS_MASK32 32'hFFFF_FFFF
// ---------------------------------------------------------------------
// Counter modes
// ---------------------------------------------------------------------
`define MTS_MODE_ONESHOT 3'h0
`define MTS_MODE_PERIODIC 3'h1
`define MTS_MODE_PWM 3'h2
`define MTS_MODE_EDGETIME 3'h3
`define MTS_MODE_EDGECNT 3'h4
`endif

// *** hw/mts_timer_top.v ***
// Timer subsystem: real-time counter, general and auxiliary timers, radio
// time base and watchdog behind a simple register port.
//
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`include "mts_defines.vh"
module mts_timer_top (
  input wire mclk_i,
  input wire resetn_i,
  input wire [8:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  input wire low_freq_sys_clock_i,
  input wire aux_clk24_i,
  input wire aux_clk2_i,
  input wire aux_clk32k_i,
  input wire radio_clk4_i,
  input wire wdog_clk_i,
  input wire shutdown_i,
  input wire standby_i,
  input wire dbg_halt_i,
  input wire radio_en_i,
  input wire [7:0] gp_evt_i,
  input wire [1:0] aux_tick_i,
  input wire [2:0] rtc_cap_i,
  input wire [3:0] aux2_cap_i,
  input wire [1:0] rat_cap_i,
  output wire [7:0] gp_out_o,
  output reg [6:0] aux_evt_o,
  output wire [3:0] aux2_wave_o,
  output reg [69:0] rtc_stamp_o,
  output reg [31:0] rat_time_o,
  output reg wdt_irq_o,
  output reg wdt_rst_o
);
  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  function [15:0] mts_pmask;
    input [3:0] n;
    reg [16:0] t;
    begin
      t = (17'h0_0001 << n) - 17'h0_0001;
      mts_pmask = t[15:0];
    end
  endfunction
  function mts_pre_hit;
    input [15:0] pre;
    input [3:0] n;
    begin
      mts_pre_hit = ((pre & mts_pmask(n)) == mts_pmask(n));
    end
  endfunction
  function [31:0] mts_rtc_to_rat;
    input [69:0] t;
    reg [91:0] p;
    begin
      p = t * `MTS_RAT_TICKS_PER_SEC;
      mts_rtc_to_rat = p[63:32];
    end
  endfunction
  // -------------------------------------------------------------------
  // Clock-rate inputs
  // -------------------------------------------------------------------
  // Slow clocks are sampled, not used as clocks, so that the whole block
  // stays in one domain; each rising level is a one-cycle tick.
  // Bits: 0 LF, 1 aux 24M, 2 aux 2M, 3 aux 32k, 4 radio 4M, 5 watchdog.
  wire [5:0] ext_clk = {wdog_clk_i, radio_clk4_i, aux_clk32k_i,
                        aux_clk2_i, aux_clk24_i, low_freq_sys_clock_i};
  reg [5:0] sy1_r;
  reg [5:0] sy2_r;
  reg [5:0] sy3_r;
  reg [5:0] lvl_r;
  reg [5:0] lvl_d_r;
  wire [5:0] rise = lvl_r & ~lvl_d_r;
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sy1_r <= 6'h00;
      sy2_r <= 6'h00;
      sy3_r <= 6'h00;
      lvl_r <= 6'h00;
      lvl_d_r <= 6'h00;
    end else begin
      sy1_r <= ext_clk;
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      lvl_r <= (sy2_r & sy3_r) | (lvl_r & (sy2_r | sy3_r));
      lvl_d_r <= lvl_r;
    end
  end
  // -------------------------------------------------------------------
  // Registers and address decode
  // -------------------------------------------------------------------
  reg [31:0] gctrl_r;
  reg [`MTS_STATUS_W-1:0] status_r;
  reg [31:0] rtc_inc_r;
  reg [8:0] rtc_chcfg_r;
  reg [11:0] aux_chcfg_r;
  reg [5:0] rat_chcfg_r;
  reg [31:0] wdt_load_r;
  reg [31:0] wdt_cnt_r;
  reg wdt_en_r;
  reg [31:0] cfg_r [0:`MTS_NUM_CNT-1];
  reg [31:0] load_r [0:`MTS_NUM_CNT-1];
  reg [31:0] match_r [0:`MTS_NUM_CNT-1];
  reg [15:0] pre_r;
  reg radio_en_d_r;
  reg [7:0] gp_evt_d_r;
  reg [1:0] aux_tick_d_r;
  reg [8:0] cap_d_r;
  wire [8:0] cnt_off = addr_i - `MTS_A_CNT_BASE;
  wire in_cnt = (addr_i >= `MTS_A_CNT_BASE) && (cnt_off < `MTS_CNT_SPAN);
  wire [3:0] cnt_idx = cnt_off[8:5];
  wire [2:0] cnt_sub = cnt_off[4:2];
  wire [8:0] ch_off = addr_i - `MTS_A_CH_BASE;
  wire in_ch = (addr_i >= `MTS_A_CH_BASE) && (addr_i < `MTS_A_CNT_BASE);
  wire [3:0] ch_idx = ch_off[5:2];
  wire kick = wr_i && (addr_i == `MTS_A_WDT_KICK);
  wire [7:0] gp_edge = gp_evt_i & ~gp_evt_d_r;
  wire [1:0] aux_edge = aux_tick_i ^ aux_tick_d_r;
  wire [8:0] cap_all = {rat_cap_i, aux2_cap_i, rtc_cap_i};
  wire [8:0] cap_edge = cap_all & ~cap_d_r;
  wire [`MTS_NUM_CNT*32-1:0] cnt_all;
  wire [`MTS_NUM_CNT*32-1:0] capt_all;
  wire [`MTS_NUM_CNT-1:0] cnt_evt;
  wire [`MTS_NUM_CNT-1:0] cnt_out;
  wire [`MTS_NUM_CH*32-1:0] ch_val;
  wire [`MTS_NUM_CH-1:0] ch_evt;
  wire [`MTS_NUM_CH-1:0] ch_wave;
  wire [26:0] ch_cfg = {rat_chcfg_r, aux_chcfg_r, rtc_chcfg_r};
  // -------------------------------------------------------------------
  // Counter steering
  // -------------------------------------------------------------------
  reg [`MTS_NUM_CNT-1:0] c_en;
  reg [`MTS_NUM_CNT-1:0] c_tick;
  reg [`MTS_NUM_CNT-1:0] c_edge;
  reg [`MTS_NUM_CNT*32-1:0] c_mask;
  integer i;
  always @* begin
    c_en = {`MTS_NUM_CNT{1'b0}};
    c_tick = {`MTS_NUM_CNT{1'b0}};
    c_edge = {`MTS_NUM_CNT{1'b0}};
    c_mask = {`MTS_NUM_CNT*32{1'b0}};
    for (i = 0; i < `MTS_NUM_CNT; i = i + 1) begin
      c_en[i] = cfg_r[i][`MTS_CF_EN];
      c_tick[i] = mts_pre_hit(pre_r, cfg_r[i][7:4]);
      c_mask[i*32 +: 32] = `MTS_MASK16;
      if (i < 8) begin
        if (gctrl_r[`MTS_GC_SPLIT_LSB + i/2] == 1'b0) begin
          if (i % 2 == 0) begin
            c_mask[i*32 +: 32] = `MTS_MASK32;
          end else begin
            c_en[i] = 1'b0;
          end
        end
        c_edge[i] = gp_edge[i];
      end else if (i < 10) begin
        if (cfg_r[i][`MTS_CF_SRC]) begin
          c_tick[i] = aux_edge[i-8];
        end
        c_edge[i] = aux_edge[i-8];
      end else begin
        case (cfg_r[i][9:8])
          2'h0: c_tick[i] = rise[1];
          2'h1: c_tick[i] = rise[2];
          2'h2: c_tick[i] = rise[3];
          default: c_tick[i] = 1'b0;
        endcase
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < `MTS_NUM_CNT; g = g + 1) begin : g_cnt
      mts_counter #(.W(32)) u_cnt (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .en_i(c_en[g]),
        .tick_i(c_tick[g]),
        .edge_i(c_edge[g]),
        .mode_i(cfg_r[g][2:0]),
        .mask_i(c_mask[g*32 +: 32]),
        .load_i(load_r[g]),
        .match_i(match_r[g]),
        .cnt_o(cnt_all[g*32 +: 32]),
        .capt_o(capt_all[g*32 +: 32]),
        .evt_o(cnt_evt[g]),
        .out_o(cnt_out[g])
      );
    end
    for (g = 0; g < `MTS_NUM_CH; g = g + 1) begin : g_ch
      wire [31:0] src = (g < 3) ? rtc_stamp_o[47:16] :
                        (g < 7) ? cnt_all[10*32 +: 32] : rat_time_o;
      mts_cc_channel #(.W(32)) u_ch (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .cnt_i(src),
        .cap_edge_i(cap_edge[g]),
        .en_i(ch_cfg[g*3]),
        .capmode_i(ch_cfg[g*3+1]),
        .periodic_i(ch_cfg[g*3+2]),
        .wr_i(wr_i && in_ch && ch_idx == g),
        .wdata_i(wdata_i),
        .val_o(ch_val[g*32 +: 32]),
        .evt_o(ch_evt[g]),
        .wave_o(ch_wave[g])
      );
    end
  endgenerate
  assign gp_out_o = cnt_out[7:0];
  assign aux2_wave_o = ch_wave[6:3];
  // -------------------------------------------------------------------
  // Watchdog and status
  // -------------------------------------------------------------------
  // Pause in standby or halt.
  wire wdt_step = wdt_en_r && rise[5] && !standby_i && !dbg_halt_i;
  wire wdt_hit = wdt_step && !kick && (wdt_cnt_r == 32'h0000_0000);
  wire [`MTS_STATUS_W-1:0] st_set = {wdt_hit, ch_evt, cnt_evt[10:0]};
  wire rtc_run = rise[0] && !shutdown_i &&
                 !(dbg_halt_i && gctrl_r[`MTS_GC_RTC_DBGSTOP]);
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gctrl_r <= `MTS_GCTRL_RST;
      status_r <= {`MTS_STATUS_W{1'b0}};
      rtc_inc_r <= `MTS_RTC_INC_RST;
      rtc_chcfg_r <= 9'h000;
      aux_chcfg_r <= 12'h000;
      rat_chcfg_r <= 6'h00;
      wdt_load_r <= `MTS_WDT_LOAD_RST;
      wdt_cnt_r <= `MTS_WDT_LOAD_RST;
      wdt_en_r <= 1'b0;
      wdt_irq_o <= 1'b0;
      wdt_rst_o <= 1'b0;
      rtc_stamp_o <= 70'h0;
      rat_time_o <= 32'h0000_0000;
      radio_en_d_r <= 1'b0;
      pre_r <= 16'h0000;
      gp_evt_d_r <= 8'h00;
      aux_tick_d_r <= 2'h0;
      cap_d_r <= 9'h000;
      aux_evt_o <= 7'h00;
      for (i = 0; i < `MTS_NUM_CNT; i = i + 1) begin
        cfg_r[i] <= 32'h0000_0000;
        load_r[i] <= 32'h0000_0000;
        match_r[i] <= 32'h0000_0000;
      end
    end else begin
      pre_r <= pre_r + 16'h0001;
      gp_evt_d_r <= gp_evt_i;
      aux_tick_d_r <= aux_tick_i;
      cap_d_r <= cap_all;
      radio_en_d_r <= radio_en_i;
      aux_evt_o <= {ch_evt[6:3], cnt_evt[10:8]};
      if (rtc_run) begin
        rtc_stamp_o <= rtc_stamp_o + {38'h0, rtc_inc_r};
      end
      if (radio_en_i && !radio_en_d_r) begin
        rat_time_o <= mts_rtc_to_rat(rtc_stamp_o);
      end else if (radio_en_i && rise[4]) begin
        rat_time_o <= rat_time_o + 32'h0000_0001;
      end
      if (wr_i && addr_i == `MTS_A_STATUS) begin
        status_r <= (status_r & ~wdata_i[`MTS_STATUS_W-1:0]) | st_set;
      end else begin
        status_r <= status_r | st_set;
      end
      if (kick) begin
        wdt_cnt_r <= wdt_load_r;
        wdt_irq_o <= 1'b0;
      end else if (wdt_step) begin
        if (wdt_hit) begin
          wdt_cnt_r <= wdt_load_r;
          if (wdt_irq_o) begin
            wdt_rst_o <= 1'b1;
          end
          wdt_irq_o <= 1'b1;
        end else begin
          wdt_cnt_r <= wdt_cnt_r - 32'h0000_0001;
        end
      end
      if (wr_i) begin
        case (addr_i)
          `MTS_A_GCTRL: gctrl_r <= wdata_i;
          `MTS_A_RTC_INC: rtc_inc_r <= wdata_i;
          `MTS_A_RTC_CHCFG: rtc_chcfg_r <= wdata_i[8:0];
          `MTS_A_AUX_CHCFG: aux_chcfg_r <= wdata_i[11:0];
          `MTS_A_RAT_CHCFG: rat_chcfg_r <= wdata_i[5:0];
          `MTS_A_WDT_LOAD: wdt_load_r <= wdata_i;
          `MTS_A_WDT_CTRL: wdt_en_r <= wdt_en_r | wdata_i[0];
          default: begin
            if (in_cnt && cnt_sub == `MTS_SUB_CFG) begin
              cfg_r[cnt_idx] <= wdata_i;
            end
            if (in_cnt && cnt_sub == `MTS_SUB_LOAD) begin
              load_r[cnt_idx] <= wdata_i;
            end
            if (in_cnt && cnt_sub == `MTS_SUB_MATCH) begin
              match_r[cnt_idx] <= wdata_i;
            end
          end
        endcase
      end
    end
  end
  // -------------------------------------------------------------------
  // Read path
  // -------------------------------------------------------------------
  // Unmapped addresses read zero; data is only valid one cycle after rd.
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (addr_i)
      `MTS_A_GCTRL: rd_nxt = gctrl_r;
      `MTS_A_STATUS: rd_nxt = {11'h000, status_r};
      `MTS_A_RTC_INC: rd_nxt = rtc_inc_r;
      `MTS_A_RTC_LO: rd_nxt = rtc_stamp_o[31:0];
      `MTS_A_RTC_MID: rd_nxt = rtc_stamp_o[63:32];
      `MTS_A_RTC_TOP: rd_nxt = {26'h0, rtc_stamp_o[69:64]};
      `MTS_A_RTC_CHCFG: rd_nxt = {23'h0, rtc_chcfg_r};
      `MTS_A_WDT_LOAD: rd_nxt = wdt_load_r;
      `MTS_A_WDT_CTRL: rd_nxt = {29'h0, wdt_rst_o, wdt_irq_o, wdt_en_r};
      `MTS_A_WDT_COUNT: rd_nxt = wdt_cnt_r;
      `MTS_A_RAT_COUNT: rd_nxt = rat_time_o;
      `MTS_A_AUX_CHCFG: rd_nxt = {20'h0, aux_chcfg_r};
      `MTS_A_RAT_CHCFG: rd_nxt = {26'h0, rat_chcfg_r};
      default: begin
        if (in_ch && ch_idx < `MTS_NUM_CH) begin
          rd_nxt = ch_val[ch_idx*32 +: 32];
        end else if (in_cnt) begin
          case (cnt_sub)
            `MTS_SUB_CFG: rd_nxt = cfg_r[cnt_idx];
            `MTS_SUB_LOAD: rd_nxt = load_r[cnt_idx];
            `MTS_SUB_MATCH: rd_nxt = match_r[cnt_idx];
            `MTS_SUB_COUNT: rd_nxt = cnt_all[cnt_idx*32 +: 32];
            `MTS_SUB_CAPT: rd_nxt = capt_all[cnt_idx*32 +: 32];
            default: rd_nxt = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      rdata_o <= rd_nxt;
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end
endmodule

// *** tb/mts_timer_chk.sv ***
// Port assertions for the timer block.
`timescale 1ns/100ps
`include "mts_defines.vh"
module mts_timer_chk (
  input wire mclk_i,
  input wire resetn_i,
  input wire [8:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire shutdown_i,
  input wire standby_i,
  input wire dbg_halt_i,
  input wire radio_en_i,
  input wire [69:0] rtc_stamp_o,
  input wire [31:0] rat_time_o,
  input wire wdt_irq_o,
  input wire wdt_rst_o
);
  // Copy of the debug-stop bit, since a halt freezes time only while set.
  reg stop_r;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  always @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i)
      stop_r <= 1'b1;
    else if (wr_i && addr_i == `MTS_A_GCTRL)
      stop_r <= wdata_i[0];
  end
  // ------
  // Checks
  // ------
  chk_rtc_pad_zero:
    assert property (rd_i && addr_i == `MTS_A_RTC_TOP
      |=> rdata_o[31:6] == 26'h0) else $error("rtc pad bits set");
  chk_rtc_off_hold:
    assert property (shutdown_i [*4] |-> $stable(rtc_stamp_o))
      else $error("rtc moved in shutdown");
  chk_rtc_dbg_hold:
    assert property ((dbg_halt_i && stop_r) [*4] |-> $stable(rtc_stamp_o))
      else $error("rtc moved in halt");
  chk_rat_off_hold:
    assert property (!radio_en_i [*3] |-> $stable(rat_time_o))
      else $error("radio time moved while off");
  chk_wdog_pause:
    assert property (((standby_i || dbg_halt_i) && !wr_i) [*4]
      |-> $stable(wdt_irq_o)) else $error("watchdog ran while paused");
  chk_rst_after_irq:
    assert property ($rose(wdt_rst_o) |-> wdt_irq_o)
      else $error("reset without interrupt");
  chk_rst_held:
    assert property (wdt_rst_o |=> wdt_rst_o) else $error("reset dropped");
  chk_kick_clears:
    assert property (wr_i && addr_i == `MTS_A_WDT_KICK |=> !wdt_irq_o)
      else $error("kick left interrupt set");
  chk_rdata_idle:
    assert property (!rd_i |=> rdata_o == 32'h0000_0000)
      else $error("read data without read strobe");
endmodule
bind mts_timer_top mts_timer_chk chk_u (.mclk_i, .resetn_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .shutdown_i, .standby_i, .dbg_halt_i,
  .radio_en_i, .rtc_stamp_o, .rat_time_o, .wdt_irq_o, .wdt_rst_o);

// *** tb/tb.sv ***
// Self-checking bench for the timer block.
`timescale 1ns/100ps
`include "mts_defines.vh"
module tb;
  reg mclk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0;
  reg shutdown_i = 1, standby_i = 0, dbg_halt_i = 0, radio_en_i = 0;
  reg [8:0] addr_i = 0;
  reg [31:0] wdata_i = 0, nz = 0, rv, inc;
  reg [2:0] sc = 0;
  reg [69:0] s = 0;
  reg [95:0] p;
  wire [31:0] rdata_o, rat_time_o;
  wire [7:0] gp_out_o;
  wire [6:0] aux_evt_o;
  wire [3:0] aux2_wave_o;
  wire [69:0] rtc_stamp_o;
  wire wdt_irq_o, wdt_rst_o;
  integer n_errors = 0, total_checks = 0, k, l, m, hi, nev = 0;
  mts_timer_top dut_u (.mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .low_freq_sys_clock_i(sc[0]), .aux_clk24_i(nz[0]),
    .aux_clk2_i(nz[1]), .aux_clk32k_i(nz[2]), .radio_clk4_i(sc[2]),
    .wdog_clk_i(sc[1]), .shutdown_i, .standby_i, .dbg_halt_i, .radio_en_i,
    .gp_evt_i(nz[10:3]), .aux_tick_i(nz[12:11]), .rtc_cap_i(nz[15:13]),
    .aux2_cap_i(nz[19:16]), .rat_cap_i(nz[21:20]), .gp_out_o, .aux_evt_o,
    .aux2_wave_o, .rtc_stamp_o, .rat_time_o, .wdt_irq_o, .wdt_rst_o);
  initial forever #5 mclk_i = ~mclk_i;
  // Unused inputs carry noise so disabled channels must ignore it.
  always @(posedge mclk_i) nz <= $urandom;
  always @(posedge mclk_i) if (aux_evt_o[0] === 1'b1) nev <= nev + 1;
  // -----
  // Tasks
  // -----
  task ck(input string nm, input logic [69:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task wr(input [8:0] a, input [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask
  task rd(input [8:0] a);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1;
    @(posedge mclk_i);
    rd_i <= 0;
    #1 rv = rdata_o;
  endtask
  task rc(input [8:0] a, input [31:0] e);
    rd(a);
    ck("register", rv, e);
  endtask
  // Slow rate clocks are sampled, so each pulse is stretched.
  task pls(input integer b, n);
    repeat (n) begin
      @(posedge mclk_i) sc[b] <= 1;
      repeat (8) @(posedge mclk_i);
      sc[b] <= 0;
      repeat (8) @(posedge mclk_i);
    end
    repeat (12) @(posedge mclk_i);
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_errors++;
    tally_and_finish;
  end
  // -----
  // Tests
  // -----
  initial begin
    rv = $urandom(2960);
    repeat (12) @(posedge mclk_i);
    resetn_i <= 1;
    wr(9'h038, $urandom);
    rc(`MTS_A_GCTRL, `MTS_GCTRL_RST);
    rc(`MTS_A_RTC_INC, `MTS_RTC_INC_RST);
    rc(`MTS_A_WDT_LOAD, `MTS_WDT_LOAD_RST);
    rc(`MTS_A_WDT_COUNT, `MTS_WDT_LOAD_RST);
    rc(`MTS_A_WDT_CTRL, 32'h0);
    rc(9'h038, 32'h0);
    $display("reset test done");
    inc = $urandom;
    wr(`MTS_A_RTC_INC, inc);
    k = 2 + $urandom % 5;
    shutdown_i <= 0;
    pls(0, k);
    shutdown_i <= 1;
    s = s + inc * k;
    pls(0, 3);
    ck("rtc", rtc_stamp_o, s);
    rc(`MTS_A_RTC_LO, s[31:0]);
    rc(`MTS_A_RTC_MID, s[63:32]);
    rc(`MTS_A_RTC_TOP, {26'h0, s[69:64]});
    shutdown_i <= 0;
    dbg_halt_i <= 1;
    pls(0, 3);
    ck("rtc halted", rtc_stamp_o, s);
    wr(`MTS_A_GCTRL, 32'h0);
    pls(0, 2);
    s = s + inc * 2;
    wr(`MTS_A_GCTRL, `MTS_GCTRL_RST);
    shutdown_i <= 1;
    dbg_halt_i <= 0;
    repeat (12) @(posedge mclk_i);
    ck("rtc no stop", rtc_stamp_o, s);
    $display("rtc test done");
    p = s * `MTS_RAT_TICKS_PER_SEC;
    radio_en_i <= 1;
    k = 1 + $urandom % 4;
    pls(2, k);
    ck("radio time", rat_time_o, 32'(p[63:32] + k));
    radio_en_i <= 0;
    pls(2, 2);
    $display("radio test done");
    l = 3 + $urandom % 16;
    m = 1 + $urandom % l;
    wr(9'h084, l);
    wr(9'h088, m);
    wr(9'h080, 32'hA);
    repeat (3 * l) @(posedge mclk_i);
    hi = 0;
    repeat (4 * l + 4) begin
      @(posedge mclk_i);
      hi = hi + (gp_out_o[0] === 1'b1);
    end
    ck("pwm high", hi, 4 * m);
    k = nev;
    wr(9'h184, l);
    wr(9'h180, 32'h8);
    repeat (4 * l + 16) @(posedge mclk_i);
    ck("oneshot events", nev - k, 1);
    rc(9'h18C, l);
    rd(`MTS_A_STATUS);
    ck("timeout flag", rv[8], 1'b1);
    wr(`MTS_A_STATUS, 32'h100);
    rd(`MTS_A_STATUS);
    ck("flag cleared", rv[8], 1'b0);
    $display("counter test done");
    l = 2 + $urandom % 4;
    wr(`MTS_A_WDT_LOAD, l);
    wr(`MTS_A_WDT_KICK, 32'h0);
    wr(`MTS_A_WDT_CTRL, 32'h1);
    pls(1, l - 1);
    ck("irq early", wdt_irq_o, 1'b0);
    pls(1, 2);
    ck("irq", {wdt_rst_o, wdt_irq_o}, 2'b01);
    wr(`MTS_A_WDT_CTRL, 32'h0);
    rd(`MTS_A_WDT_CTRL);
    ck("wdog enable", rv[0], 1'b1);
    wr(`MTS_A_WDT_KICK, 32'h0);
    @(posedge mclk_i);
    ck("irq kicked", wdt_irq_o, 1'b0);
    standby_i <= 1;
    rd(`MTS_A_WDT_COUNT);
    k = rv;
    pls(1, 3);
    rd(`MTS_A_WDT_COUNT);
    ck("wdog paused", rv, k);
    standby_i <= 0;
    pls(1, 2 * l + 2);
    ck("wdog reset", {wdt_rst_o, wdt_irq_o}, 2'b11);
    $display("watchdog test done");
    tally_and_finish;
  end
endmodule
